// ===== design/eis_error_interrupt_status.sv
// Summary of operation
// R1: Error status register, 32 bits, at offset 0x414, apart from normal status.
// R2: Bit 31 reads as OR of all normal status register bits; the code ORs only bits 30 to 0.
// R3: Processor bus retry-limit flags for PCI-1, PCI-2 and processor bus DMA cycles.
// R4: Processor bus transfer-error-acknowledge flags for PCI-1, PCI-2 and DMA cycles.
// R5: Processor bus address parity error sets its own sticky flag.
// R6: Processor bus data parity flags for PCI-1, PCI-2 and DMA cycles.
// R7: PCI-2 error flags per PCI-1, processor bus, DMA; software checks PCI-2 CSR.
// R8: PCI-2 address parity error sets its own sticky flag.
// R9: PCI-2 master retry-limit flags per PCI-1, processor bus or DMA initiator.
// R10: Single-PCI variant keeps every PCI-2 flag reserved and clear.
// R11: PCI-1 error flags per PCI-2, processor bus, DMA; software checks PCI-1 CSR.
// R12: PCI-1 retry-limit flags per initiator, plus PCI-1 address parity flag.
// R13: Write one clears a flag, zero keeps it; reserved bits read zero.
// R14: Global reset clears every flag.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module eis_error_interrupt_status
  import eis_pkg::*;
#(
  parameter bit SINGLE_PCI = 1'b0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] errEvent,
  input wire logic [31:0] normalStatus,
  output logic errorStatusAny
);

  // ----------------------------------------------------------------
  // Variant masking
  // ----------------------------------------------------------------
  // The single-PCI part has no PCI-2 port, so those flags are pinned low
  localparam logic [31:0] EFF_MASK =
    SINGLE_PCI ? (EIS_FLAG_MASK & ~EIS_PCI2_MASK) : EIS_FLAG_MASK; // R10

  logic [31:0] flags;
  logic [31:0] eventVec;
  logic [31:0] clrVec;
  logic [31:0] laneMask;
  logic [31:0] statusWord;
  logic normalAny;
  logic addrHit;
  logic wrAccess;
  logic rdSetup;

  // ----------------------------------------------------------------
  // Event inputs
  // ----------------------------------------------------------------
  // Events come from bridge logic on clk, so no synchroniser is needed;
  // reserved positions are dropped here
  assign eventVec = errEvent & EFF_MASK; // R3 R4 R5 R6 R7 R8 R9 R11 R12

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign addrHit = (paddr == EIS_ERR_STATUS_OFFSET); // R1
  assign wrAccess = psel && penable && pwrite && addrHit;
  assign rdSetup = psel && !penable && !pwrite;

  // Byte strobes limit which flags a write may clear
  always_comb
  begin
    for (int i = 0; i < EIS_BYTES; i++)
    begin
      laneMask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Write one to clear; zeros leave flags alone
  assign clrVec = wrAccess ? (pwdata & laneMask & EFF_MASK) : '0; // R13

  // ----------------------------------------------------------------
  // Sticky flag bytes
  // ----------------------------------------------------------------
  for (genvar g = 0; g < EIS_BYTES; g++)
  begin : gByte
    eis_byte_if byteBus();
    assign byteBus.setEv = eventVec[g*8 +: 8];
    assign byteBus.clrEv = clrVec[g*8 +: 8];
    assign flags[g*8 +: 8] = byteBus.flags;
    eis_flag_byte #(
      .VALID(EFF_MASK[g*8 +: 8])
    ) uFlags (
      .clk(clk),
      .nrst(nrst),
      .bus(byteBus)
    );
  end

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // Summary bit follows the normal status live, it is not latched
  assign normalAny = |(normalStatus & EIS_NORMAL_MASK); // R2

  always_comb
  begin
    statusWord = flags & EFF_MASK; // R13
    statusWord[EIS_NORMAL_ANY_BIT] = normalAny; // R2
  end

  // Feeds the summary bit of the normal status register
  assign errorStatusAny = |flags;

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  // Read data is snapshotted in the setup cycle so it stands steady
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata <= EIS_ERR_STATUS_RESET;
    end
    else if (rdSetup)
    begin
      prdata <= addrHit ? statusWord : EIS_UNMAPPED_READ; // R1
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Same-cycle event beats a clear of the same flag
  a_event_sets_flag: assert property ( // R3 R4 R5 R6 R7 R8 R9 R11 R12
    (eventVec != '0) |=> ((flags & $past(eventVec)) == $past(eventVec))
  ) else $error("event did not set its flag");

  // Writing one clears when no event races it
  a_write_one_clears: assert property ( // R13
    (wrAccess && ((pwdata & laneMask & EFF_MASK & ~eventVec) != '0))
      |=> ((flags & $past(clrVec) & ~$past(eventVec)) == '0)
  ) else $error("write one did not clear flag");

  // Without event or clear the flags hold
  a_flags_sticky: assert property ( // R13
    (eventVec == '0 && clrVec == '0) |=> (flags == $past(flags))
  ) else $error("flag changed with no cause");

  // A disabled strobe on lane 0 shields the flags of byte 0
  a_lane_protect: assert property ( // R13
    (wrAccess && !pstrb[0] && eventVec[7:0] == 8'h00)
      |=> (flags[7:0] == $past(flags[7:0]))
  ) else $error("unstrobed lane was cleared");

  // Reserved and zero positions never hold a one
  a_reserved_zero: assert property ( // R13 R10
    (flags & ~EFF_MASK) == '0
  ) else $error("reserved flag bit set");

  // PCI-2 flags stay clear on the single-PCI part
  a_pci2_quiet: assert property ( // R10
    SINGLE_PCI |-> ((flags & EIS_PCI2_MASK) == '0)
  ) else $error("PCI-2 flag set in single-PCI mode");

  // Read data carries the flags and summary from the setup cycle
  a_read_data: assert property ( // R1 R2
    (psel && penable && !pwrite && addrHit)
      |-> (prdata[30:0] == ($past(flags[30:0]) & EFF_MASK[30:0]))
        && (prdata[EIS_NORMAL_ANY_BIT] ==
            (|($past(normalStatus) & EIS_NORMAL_MASK)))
  ) else $error("read data mismatch");

  // Unmapped addresses answer with an error and zero data
  a_unmapped_err: assert property ( // R1
    (psel && penable && !addrHit)
      |-> (pslverr && pready && (pwrite || prdata == EIS_UNMAPPED_READ))
  ) else $error("unmapped access not refused");

  // Reset clears every flag and read data
  a_reset_clears: assert property ( // R14
    disable iff (1'b0)
    !nrst |=> (flags == EIS_ERR_STATUS_RESET) && (prdata == EIS_ERR_STATUS_RESET)
  ) else $error("reset left a flag set");

  // Error summary tracks the flags after two quiet cycles
  a_summary_out: assert property ( // R13
    (eventVec == '0 && clrVec == '0)[*2] |-> (errorStatusAny == ($past(flags) != '0))
  ) else $error("error summary wrong");

  // ----------------------------------------------------------------
  // Field positions, checked bit by bit from the raw event inputs
  // ----------------------------------------------------------------
  // Processor bus retry limit on a PCI-1 cycle
  a_bus_retry_pci1: assert property ( // R3
    errEvent[EIS_PROCBUS_PCI1_RETRY_BIT] |=> flags[EIS_PROCBUS_PCI1_RETRY_BIT]
  ) else $error("bus retry flag for PCI-1 not set");

  // Processor bus retry limit on a PCI-2 cycle, absent on the single-PCI part
  a_bus_retry_pci2: assert property ( // R3 R10
    errEvent[EIS_PROCBUS_PCI2_RETRY_BIT] |=> (flags[EIS_PROCBUS_PCI2_RETRY_BIT] == !SINGLE_PCI)
  ) else $error("bus retry flag for PCI-2 wrong");

  // Processor bus retry limit during bus-to-bus DMA
  a_bus_retry_dma: assert property ( // R3
    errEvent[EIS_PROCBUS_DMA_RETRY_BIT] |=> flags[EIS_PROCBUS_DMA_RETRY_BIT]
  ) else $error("bus retry flag for DMA not set");

  // Transfer error acknowledge on a PCI-1 cycle
  a_bus_terr_pci1: assert property ( // R4
    errEvent[EIS_PROCBUS_PCI1_TERR_BIT] |=> flags[EIS_PROCBUS_PCI1_TERR_BIT]
  ) else $error("bus transfer error flag for PCI-1 not set");

  // Transfer error acknowledge on a PCI-2 cycle
  a_bus_terr_pci2: assert property ( // R4 R10
    errEvent[EIS_PROCBUS_PCI2_TERR_BIT] |=> (flags[EIS_PROCBUS_PCI2_TERR_BIT] == !SINGLE_PCI)
  ) else $error("bus transfer error flag for PCI-2 wrong");

  // Transfer error acknowledge during bus-to-bus DMA
  a_bus_terr_dma: assert property ( // R4
    errEvent[EIS_PROCBUS_DMA_TERR_BIT] |=> flags[EIS_PROCBUS_DMA_TERR_BIT]
  ) else $error("bus transfer error flag for DMA not set");

  // Processor bus address parity
  a_bus_addr_parity: assert property ( // R5
    errEvent[EIS_PROCBUS_APAR_BIT] |=> flags[EIS_PROCBUS_APAR_BIT]
  ) else $error("bus address parity flag not set");

  // Processor bus data parity on a PCI-1 cycle
  a_bus_dpar_pci1: assert property ( // R6
    errEvent[EIS_PROCBUS_PCI1_DPAR_BIT] |=> flags[EIS_PROCBUS_PCI1_DPAR_BIT]
  ) else $error("bus data parity flag for PCI-1 not set");

  // Processor bus data parity on a PCI-2 cycle
  a_bus_dpar_pci2: assert property ( // R6 R10
    errEvent[EIS_PROCBUS_PCI2_DPAR_BIT] |=> (flags[EIS_PROCBUS_PCI2_DPAR_BIT] == !SINGLE_PCI)
  ) else $error("bus data parity flag for PCI-2 wrong");

  // Processor bus data parity during bus-to-bus DMA
  a_bus_dpar_dma: assert property ( // R6
    errEvent[EIS_PROCBUS_DMA_DPAR_BIT] |=> flags[EIS_PROCBUS_DMA_DPAR_BIT]
  ) else $error("bus data parity flag for DMA not set");

  // PCI-2 error on a cycle to or from PCI-1
  a_pci2_err_pci1: assert property ( // R7 R10
    errEvent[EIS_PCI2_TO_PCI1_ERR_BIT] |=> (flags[EIS_PCI2_TO_PCI1_ERR_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 error flag for PCI-1 wrong");

  // PCI-2 error on a cycle to or from the processor bus
  a_pci2_err_bus: assert property ( // R7 R10
    errEvent[EIS_PCI2_TO_PROCBUS_ERR_BIT] |=> (flags[EIS_PCI2_TO_PROCBUS_ERR_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 error flag for processor bus wrong");

  // PCI-2 error during its own DMA
  a_pci2_err_dma: assert property ( // R7 R10
    errEvent[EIS_PCI2_DMA_ERR_BIT] |=> (flags[EIS_PCI2_DMA_ERR_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 error flag for DMA wrong");

  // PCI-2 address parity
  a_pci2_addr_parity: assert property ( // R8 R10
    errEvent[EIS_PCI2_APAR_BIT] |=> (flags[EIS_PCI2_APAR_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 address parity flag wrong");

  // PCI-2 master retries on a cycle from PCI-1
  a_pci2_retry_pci1: assert property ( // R9 R10
    errEvent[EIS_PCI2_FROM_PCI1_RETRY_BIT] |=> (flags[EIS_PCI2_FROM_PCI1_RETRY_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 retry flag for PCI-1 wrong");

  // PCI-2 master retries on a cycle from the processor bus
  a_pci2_retry_bus: assert property ( // R9 R10
    errEvent[EIS_PCI2_FROM_PROCBUS_RETRY_BIT]
      |=> (flags[EIS_PCI2_FROM_PROCBUS_RETRY_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 retry flag for processor bus wrong");

  // PCI-2 master retries during its own DMA
  a_pci2_retry_dma: assert property ( // R9 R10
    errEvent[EIS_PCI2_DMA_RETRY_BIT] |=> (flags[EIS_PCI2_DMA_RETRY_BIT] == !SINGLE_PCI)
  ) else $error("PCI-2 retry flag for DMA wrong");

  // PCI-1 error on a cycle to or from PCI-2
  a_pci1_err_pci2: assert property ( // R11 R10
    errEvent[EIS_PCI1_TO_PCI2_ERR_BIT] |=> (flags[EIS_PCI1_TO_PCI2_ERR_BIT] == !SINGLE_PCI)
  ) else $error("PCI-1 error flag for PCI-2 wrong");

  // PCI-1 error on a cycle to or from the processor bus
  a_pci1_err_bus: assert property ( // R11
    errEvent[EIS_PCI1_TO_PROCBUS_ERR_BIT] |=> flags[EIS_PCI1_TO_PROCBUS_ERR_BIT]
  ) else $error("PCI-1 error flag for processor bus not set");

  // PCI-1 error during its own DMA
  a_pci1_err_dma: assert property ( // R11
    errEvent[EIS_PCI1_DMA_ERR_BIT] |=> flags[EIS_PCI1_DMA_ERR_BIT]
  ) else $error("PCI-1 error flag for DMA not set");

  // PCI-1 address parity
  a_pci1_addr_parity: assert property ( // R12
    errEvent[EIS_PCI1_APAR_BIT] |=> flags[EIS_PCI1_APAR_BIT]
  ) else $error("PCI-1 address parity flag not set");

  // PCI-1 master retries on a cycle from PCI-2
  a_pci1_retry_pci2: assert property ( // R12 R10
    errEvent[EIS_PCI1_FROM_PCI2_RETRY_BIT] |=> (flags[EIS_PCI1_FROM_PCI2_RETRY_BIT] == !SINGLE_PCI)
  ) else $error("PCI-1 retry flag for PCI-2 wrong");

  // PCI-1 master retries on a cycle from the processor bus
  a_pci1_retry_bus: assert property ( // R12
    errEvent[EIS_PCI1_FROM_PROCBUS_RETRY_BIT] |=> flags[EIS_PCI1_FROM_PROCBUS_RETRY_BIT]
  ) else $error("PCI-1 retry flag for processor bus not set");

  // PCI-1 master retries during its own DMA
  a_pci1_retry_dma: assert property ( // R12
    errEvent[EIS_PCI1_DMA_RETRY_BIT] |=> flags[EIS_PCI1_DMA_RETRY_BIT]
  ) else $error("PCI-1 retry flag for DMA not set");

endmodule

`default_nettype wire

// ===== design/eis_pkg.sv
package eis_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] EIS_ERR_STATUS_OFFSET = 32'h0000_0414;
  localparam logic [31:0] EIS_ERR_STATUS_RESET = 32'h0000_0000;
  localparam logic [7:0] EIS_FLAG_BYTE_RESET = 8'h00;
  localparam logic [31:0] EIS_UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field layout of the error status register
  // ----------------------------------------------------------------
  localparam int EIS_NORMAL_ANY_BIT = 31;
  localparam int EIS_PROCBUS_PCI1_RETRY_BIT = 27;
  localparam int EIS_PROCBUS_PCI2_RETRY_BIT = 26;
  localparam int EIS_PROCBUS_DMA_RETRY_BIT = 25;
  localparam int EIS_PROCBUS_PCI1_TERR_BIT = 23;
  localparam int EIS_PROCBUS_PCI2_TERR_BIT = 22;
  localparam int EIS_PROCBUS_DMA_TERR_BIT = 21;
  localparam int EIS_PROCBUS_APAR_BIT = 20;
  localparam int EIS_PROCBUS_PCI1_DPAR_BIT = 19;
  localparam int EIS_PROCBUS_PCI2_DPAR_BIT = 18;
  localparam int EIS_PROCBUS_DMA_DPAR_BIT = 17;
  localparam int EIS_PCI2_TO_PCI1_ERR_BIT = 15;
  localparam int EIS_PCI2_TO_PROCBUS_ERR_BIT = 14;
  localparam int EIS_PCI2_DMA_ERR_BIT = 13;
  localparam int EIS_PCI2_APAR_BIT = 12;
  localparam int EIS_PCI2_FROM_PCI1_RETRY_BIT = 11;
  localparam int EIS_PCI2_FROM_PROCBUS_RETRY_BIT = 10;
  localparam int EIS_PCI2_DMA_RETRY_BIT = 9;
  localparam int EIS_PCI1_TO_PCI2_ERR_BIT = 7;
  localparam int EIS_PCI1_TO_PROCBUS_ERR_BIT = 6;
  localparam int EIS_PCI1_DMA_ERR_BIT = 5;
  localparam int EIS_PCI1_APAR_BIT = 4;
  localparam int EIS_PCI1_FROM_PCI2_RETRY_BIT = 3;
  localparam int EIS_PCI1_FROM_PROCBUS_RETRY_BIT = 2;
  localparam int EIS_PCI1_DMA_RETRY_BIT = 1;
  localparam int EIS_BYTES = 4;

  // Sticky flag positions, and those that concern PCI-2 traffic
  localparam logic [31:0] EIS_FLAG_MASK = 32'h0EFE_FEFE;
  localparam logic [31:0] EIS_PCI2_MASK = 32'h0444_FE88;
  // Normal status bits that count toward the summary (its own summary bit excluded)
  localparam logic [31:0] EIS_NORMAL_MASK = 32'h7FFF_FFFF;

endpackage

// ===== design/eis_byte_if.sv
`timescale 1ns/1ps
`default_nettype none

// Events, clears and flags of one byte of sticky status
interface eis_byte_if;
  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic [7:0] flags;
  modport owner(input setEv, input clrEv, output flags);
  modport user(output setEv, output clrEv, input flags);
endinterface

`default_nettype wire

// ===== design/eis_flag_byte.sv
`timescale 1ns/1ps
`default_nettype none

module eis_flag_byte
  import eis_pkg::*;
#(
  parameter logic [7:0] VALID = 8'hFE
)
(
  input wire logic clk,
  input wire logic nrst,
  eis_byte_if.owner bus
);

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle is kept
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.flags <= EIS_FLAG_BYTE_RESET; // R14
    end
    else
    begin
      bus.flags <= ((bus.flags & ~bus.clrEv) | bus.setEv) & VALID; // R13
    end
  end

endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import eis_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, reference state and design instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] errEvent = 32'h0;
  logic [31:0] normalStatus = 32'h0;
  logic [31:0] model = 32'h0;
  logic [31:0] prdata, prdata2;
  logic pready, pready2, pslverr, pslverr2, anyErr, anyErr2;
  int nFail = 0;
  int totalChecks = 0;
  int cyc = 0;

  eis_error_interrupt_status uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .errEvent, .normalStatus, .errorStatusAny(anyErr));
  // Single-PCI variant shares every input, so one model serves both
  eis_error_interrupt_status #(.SINGLE_PCI(1'b1)) uutSingle (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata2), .pready(pready2),
    .pslverr(pslverr2), .errEvent, .normalStatus, .errorStatusAny(anyErr2));

  // 50 MHz clock
  always #10 clk = ~clk;

  // Reference flags: set beats clear, clears gated by mapped write and byte lanes
  always @(posedge clk)
  begin
    if (!nrst)
      model <= 32'h0;
    else
      model <= (model & ~((psel && penable && pwrite && paddr == EIS_ERR_STATUS_OFFSET) ?
        pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} : 32'h0))
        | (errEvent & EIS_FLAG_MASK);
  end

  // Hang guard, far above the fewer than 800 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      nFail++;
      tallyAndFinish;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data,
    input logic [3:0] strb);
    logic hit;
    logic [31:0] expRd, rd, rd2;
    logic err, err2, rdy2;
    hit = (addr == EIS_ERR_STATUS_OFFSET);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    #1;
    expRd = hit ? (model | {|normalStatus[30:0], 31'h0}) : EIS_UNMAPPED_READ;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1); // Only the bench timeout ends a stuck wait
    rd = prdata;
    rd2 = prdata2;
    err = pslverr;
    err2 = pslverr2;
    rdy2 = pready2;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    chk("pslverr", {31'h0, err}, {31'h0, !hit});
    chk("pslverr single", {31'h0, err2}, {31'h0, !hit});
    chk("pready single", {31'h0, rdy2}, 32'h1);
    if (!wr)
    begin
      chk("prdata", rd, expRd);
      chk("prdata single", rd2, expRd & ~EIS_PCI2_MASK);
    end
    chk("summary", {31'h0, anyErr}, {31'h0, |model});
    chk("summary single", {31'h0, anyErr2}, {31'h0, |(model & ~EIS_PCI2_MASK)});
  endtask

  // Event word for one cycle, with a fresh normal status (zero half the time)
  task automatic pulse(input logic [31:0] ev);
    @(posedge clk);
    errEvent <= ev;
    normalStatus <= ($urandom_range(1, 0) == 1) ? $urandom : 32'h0;
    @(posedge clk);
    errEvent <= 32'h0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(40393));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
    // Every event position alone, then a random partial clear
    for (int b = 0; b < 32; b++)
    begin
      pulse(32'h1 << b);
      apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
      apb(1'b1, EIS_ERR_STATUS_OFFSET, $urandom, 4'($urandom));
    end
    // Mixed events, clears under random strobes, each clear followed by a read
    for (int i = 0; i < 60; i++)
    begin
      pulse($urandom);
      apb(1'b1, EIS_ERR_STATUS_OFFSET, $urandom, 4'($urandom));
      apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
    end
    // Unmapped neighbours refuse and must not clear; zero writes keep flags
    pulse(32'hFFFF_FFFF);
    apb(1'b1, EIS_ERR_STATUS_OFFSET + 32'h4, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, EIS_ERR_STATUS_OFFSET - 32'h4, 32'h0, 4'h0);
    apb(1'b1, EIS_ERR_STATUS_OFFSET, 32'h0, 4'hF);
    apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
    // Reset in mid-run wipes the flags
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
    pulse(32'hFFFF_FFFF);
    apb(1'b1, EIS_ERR_STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, EIS_ERR_STATUS_OFFSET, 32'h0, 4'h0);
    tallyAndFinish;
  end

endmodule

`default_nettype wire
